//--- verilog/sfd_cmd_consts.vh
/*
 Opcode, group and prefix constants for the serial flash command decoder.
 Assumes inclusion by the decoder only; definitions only.
*/
`ifndef SFD_CMD_CONSTS_VH
`define SFD_CMD_CONSTS_VH

// Command groups
`define SFD_GRP_A       3'h0
`define SFD_GRP_B       3'h1
`define SFD_GRP_C       3'h2
`define SFD_GRP_D       3'h3
`define SFD_GRP_OTHER   3'h4

// Read class
`define SFD_OP_PG_RD    8'hd2
`define SFD_OP_CR_LP    8'h01
`define SFD_OP_CR_LF    8'h03
`define SFD_OP_CR_HF1   8'h0b
`define SFD_OP_CR_HF2   8'h1b
`define SFD_OP_CR_OLD   8'he8
`define SFD_OP_B1_RD_LF 8'hd1
`define SFD_OP_B2_RD_LF 8'hd3
`define SFD_OP_B1_RD_HF 8'hd4
`define SFD_OP_B2_RD_HF 8'hd6
`define SFD_OP_PROT_RD  8'h32
`define SFD_OP_SEC_RD   8'h77
// Legacy
`define SFD_OP_L_B1_RD  8'h54
`define SFD_OP_L_B2_RD  8'h56
`define SFD_OP_L_PG_RD  8'h52
`define SFD_OP_L_CR     8'h68
`define SFD_OP_L_STAT   8'h57
// Buffer write and program / erase
`define SFD_OP_B1_WR    8'h84
`define SFD_OP_B2_WR    8'h87
`define SFD_OP_B1_PE    8'h83
`define SFD_OP_B2_PE    8'h86
`define SFD_OP_B1_PN    8'h88
`define SFD_OP_B2_PN    8'h89
`define SFD_OP_TB1_PE   8'h82
`define SFD_OP_TB2_PE   8'h85
`define SFD_OP_TB1_PN   8'h02
`define SFD_OP_PG_ER    8'h81
`define SFD_OP_BLK_ER   8'h50
`define SFD_OP_SEC_ER   8'h7c
`define SFD_OP_RW_B1    8'h58
`define SFD_OP_RW_B2    8'h59
`define SFD_OP_XF_B1    8'h53
`define SFD_OP_XF_B2    8'h55
`define SFD_OP_CMP_B1   8'h60
`define SFD_OP_CMP_B2   8'h61
// Power, status, identification
`define SFD_OP_DPD      8'hb9
`define SFD_OP_DPD_RES  8'hab
`define SFD_OP_UDPD     8'h79
`define SFD_OP_STAT     8'hd7
`define SFD_OP_ID       8'h9f
// Four-byte sequences
`define SFD_PFX_CE1     8'hc7
`define SFD_PFX_CE2     8'h94
`define SFD_PFX_CE3     8'h80
`define SFD_PFX_CE4     8'h9a
`define SFD_PFX_P1      8'h3d
`define SFD_PFX_P2      8'h2a
`define SFD_PFX_PROT    8'h7f
`define SFD_PFX_PGSZ    8'h80
`define SFD_X_PROT_EN   8'ha9
`define SFD_X_PROT_DIS  8'h9a
`define SFD_X_PREG_ER   8'hcf
`define SFD_X_PREG_PG   8'hfc
`define SFD_X_PG_512    8'ha6
`define SFD_X_PG_528    8'ha7
`define SFD_PFX_RST     8'hf0
`define SFD_X_ZERO      8'h00

// Counter end and saturation values
`define SFD_BIT_LAST    3'h7
`define SFD_BYTE_LAST   3'h3
`define SFD_BYTE_SAT    3'h4

`endif

//--- verilog/sfd_cmd_decoder.v
/*
 Serial flash command decoder and concurrency checker.
 Assumes an SPI host on cs_n_pin/sck_pin/si_pin (mode 0 or 3, sampled on
 rising sclk, at most a quarter of core_clk), and a self-timed engine on
 core_clk reporting its busy state on eng_busy, eng_grp_d and eng_buf.
*/
// Behaviour
// - Status runs while busy; ID and other-buffer write too, unless group D busy
// - Self-timed group: erases, transfers, compares, programs, rewrites
// - Group C and group D membership
// - D2h, 01h, 03h read opcodes
// - 0Bh, 1Bh, E8h continuous reads
// - D1h, D3h, D4h, D6h buffer reads
// - 84h, 87h buffer writes
// - 83h, 86h, 88h, 89h buffer programs
// - 82h, 85h, 02h programs through buffer
// - Erases incl. four-byte chip erase
// - 58h, 59h auto page rewrite
// - Four-byte protection command decode
// - 32h, 77h register reads
// - 53h, 55h transfer; 60h, 61h compare
// - B9h, ABh, 79h power-down opcodes
// - D7h status, 9Fh identification
// - Four-byte page size configuration
// - F0h 00h 00h 00h software reset
// - Legacy opcodes 54h 56h 52h 68h 57h
`timescale 1ns/1ps
`include "sfd_cmd_consts.vh"

module sfd_cmd_decoder (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       cs_n_pin,
    input  wire       sck_pin,
    input  wire       si_pin,
    input  wire       eng_busy,
    input  wire       eng_grp_d,
    input  wire       eng_buf,
    output reg        cmd_stb_r,
    output reg        cmd_rej_r,
    output reg        cmd_unk_r,
    output reg  [7:0] cmd_op_r,
    output reg  [7:0] cmd_ext_r,
    output reg  [2:0] cmd_grp_r,
    output reg        cmd_buf_r,
    output reg        cmd_legacy_r,
    output reg        st_active_r,
    output reg        swrst_r
);

////////////////////////////////////////////////////////////////////////////////
// Single-byte decode: {known, legacy, group[2:0], buffer}

function [5:0] sfd_decode;
    input [7:0] op;
    begin
        case (op)
            `SFD_OP_PG_RD:    sfd_decode = {2'b10, `SFD_GRP_A, 1'b0};
            `SFD_OP_CR_LP:    sfd_decode = {2'b10, `SFD_GRP_A, 1'b0};
            `SFD_OP_CR_LF:    sfd_decode = {2'b10, `SFD_GRP_A, 1'b0};
            `SFD_OP_CR_HF1:   sfd_decode = {2'b10, `SFD_GRP_A, 1'b0};
            `SFD_OP_CR_HF2:   sfd_decode = {2'b10, `SFD_GRP_A, 1'b0};
            `SFD_OP_CR_OLD:   sfd_decode = {2'b11, `SFD_GRP_A, 1'b0};
            `SFD_OP_B1_RD_LF: sfd_decode = {2'b10, `SFD_GRP_A, 1'b0};
            `SFD_OP_B2_RD_LF: sfd_decode = {2'b10, `SFD_GRP_A, 1'b1};
            `SFD_OP_B1_RD_HF: sfd_decode = {2'b10, `SFD_GRP_A, 1'b0};
            `SFD_OP_B2_RD_HF: sfd_decode = {2'b10, `SFD_GRP_A, 1'b1};
            `SFD_OP_PROT_RD:  sfd_decode = {2'b10, `SFD_GRP_A, 1'b0};
            `SFD_OP_SEC_RD:   sfd_decode = {2'b10, `SFD_GRP_A, 1'b0};
            `SFD_OP_L_B1_RD:  sfd_decode = {2'b11, `SFD_GRP_A, 1'b0};
            `SFD_OP_L_B2_RD:  sfd_decode = {2'b11, `SFD_GRP_A, 1'b1};
            `SFD_OP_L_PG_RD:  sfd_decode = {2'b11, `SFD_GRP_A, 1'b0};
            `SFD_OP_L_CR:     sfd_decode = {2'b11, `SFD_GRP_A, 1'b0};
            `SFD_OP_L_STAT:   sfd_decode = {2'b11, `SFD_GRP_C, 1'b0};
            `SFD_OP_B1_WR:    sfd_decode = {2'b10, `SFD_GRP_C, 1'b0};
            `SFD_OP_B2_WR:    sfd_decode = {2'b10, `SFD_GRP_C, 1'b1};
            `SFD_OP_B1_PE:    sfd_decode = {2'b10, `SFD_GRP_B, 1'b0};
            `SFD_OP_B2_PE:    sfd_decode = {2'b10, `SFD_GRP_B, 1'b1};
            `SFD_OP_B1_PN:    sfd_decode = {2'b10, `SFD_GRP_B, 1'b0};
            `SFD_OP_B2_PN:    sfd_decode = {2'b10, `SFD_GRP_B, 1'b1};
            `SFD_OP_TB1_PE:   sfd_decode = {2'b10, `SFD_GRP_B, 1'b0};
            `SFD_OP_TB2_PE:   sfd_decode = {2'b10, `SFD_GRP_B, 1'b1};
            `SFD_OP_TB1_PN:   sfd_decode = {2'b10, `SFD_GRP_B, 1'b0};
            `SFD_OP_PG_ER:    sfd_decode = {2'b10, `SFD_GRP_B, 1'b0};
            `SFD_OP_BLK_ER:   sfd_decode = {2'b10, `SFD_GRP_B, 1'b0};
            `SFD_OP_SEC_ER:   sfd_decode = {2'b10, `SFD_GRP_B, 1'b0};
            `SFD_OP_RW_B1:    sfd_decode = {2'b10, `SFD_GRP_B, 1'b0};
            `SFD_OP_RW_B2:    sfd_decode = {2'b10, `SFD_GRP_B, 1'b1};
            `SFD_OP_XF_B1:    sfd_decode = {2'b10, `SFD_GRP_B, 1'b0};
            `SFD_OP_XF_B2:    sfd_decode = {2'b10, `SFD_GRP_B, 1'b1};
            `SFD_OP_CMP_B1:   sfd_decode = {2'b10, `SFD_GRP_B, 1'b0};
            `SFD_OP_CMP_B2:   sfd_decode = {2'b10, `SFD_GRP_B, 1'b1};
            `SFD_OP_DPD:      sfd_decode = {2'b10, `SFD_GRP_OTHER, 1'b0};
            `SFD_OP_DPD_RES:  sfd_decode = {2'b10, `SFD_GRP_OTHER, 1'b0};
            `SFD_OP_UDPD:     sfd_decode = {2'b10, `SFD_GRP_OTHER, 1'b0};
            `SFD_OP_STAT:     sfd_decode = {2'b10, `SFD_GRP_C, 1'b0};
            `SFD_OP_ID:       sfd_decode = {2'b10, `SFD_GRP_C, 1'b0};
            default:          sfd_decode = {2'b00, `SFD_GRP_OTHER, 1'b0};
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg        cs_s1;
reg        cs_s2;
reg        cs_d;
reg        sck_s1;
reg        sck_s2;
reg        sck_d;
reg        si_s1;
reg        si_s2;

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        cs_s1  <= 1'b1;
        cs_s2  <= 1'b1;
        cs_d   <= 1'b1;
        sck_s1 <= 1'b0;
        sck_s2 <= 1'b0;
        sck_d  <= 1'b0;
        si_s1  <= 1'b0;
        si_s2  <= 1'b0;
    end else begin
        cs_s1  <= cs_n_pin;
        cs_s2  <= cs_s1;
        cs_d   <= cs_s2;
        sck_s1 <= sck_pin;
        sck_s2 <= sck_s1;
        sck_d  <= sck_s2;
        si_s1  <= si_pin;
        si_s2  <= si_s1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Frame state

reg  [7:0] shift_r;
reg  [2:0] bit_cnt_r;
reg  [2:0] byte_cnt_r;
reg        done_r;
reg        rst_arm_r;
reg  [7:0] op1_r;
reg  [7:0] b2_r;
reg  [7:0] b3_r;

wire       cs_fall  = ~cs_s2 & cs_d;
wire       cs_rise  = cs_s2 & ~cs_d;
wire       sck_rise = ~cs_s2 & sck_s2 & ~sck_d;
wire [7:0] new_byte = {shift_r[6:0], si_s2};
wire       byte_end = sck_rise & (bit_cnt_r == `SFD_BIT_LAST);
wire [5:0] dec      = sfd_decode(new_byte);

////////////////////////////////////////////////////////////////////////////////
// Command resolution

reg        hit;
reg        miss;
reg  [2:0] grp;
reg        bsel;
reg        legacy;
reg        is_rst;
reg        is_stat;
reg        is_bwr;
reg        rej;
reg        pfx_p;

always @* begin
    hit     = 1'b0;
    miss    = 1'b0;
    grp     = `SFD_GRP_OTHER;
    bsel    = 1'b0;
    legacy  = 1'b0;
    is_rst  = 1'b0;
    pfx_p   = (op1_r == `SFD_PFX_P1) && (b2_r == `SFD_PFX_P2);
    if (byte_end && !done_r && byte_cnt_r == 3'h0) begin
        if (new_byte != `SFD_PFX_CE1 && new_byte != `SFD_PFX_P1 &&
            new_byte != `SFD_PFX_RST) begin
            hit    = dec[5];
            miss   = ~dec[5];
            legacy = dec[4];
            grp    = dec[3:1];
            bsel   = dec[0];
        end
    end else if (byte_end && !done_r && byte_cnt_r == `SFD_BYTE_LAST) begin
        miss = 1'b1;
        if (op1_r == `SFD_PFX_CE1 && b2_r == `SFD_PFX_CE2 &&
            b3_r == `SFD_PFX_CE3 && new_byte == `SFD_PFX_CE4) begin
            hit = 1'b1;
            grp = `SFD_GRP_B;
        end
        if (pfx_p && b3_r == `SFD_PFX_PROT) begin
            if (new_byte == `SFD_X_PROT_EN || new_byte == `SFD_X_PROT_DIS) begin
                hit = 1'b1;
            end
            if (new_byte == `SFD_X_PREG_ER || new_byte == `SFD_X_PREG_PG) begin
                hit = 1'b1;
                grp = `SFD_GRP_D;
            end
        end
        if (pfx_p && b3_r == `SFD_PFX_PGSZ &&
            (new_byte == `SFD_X_PG_512 || new_byte == `SFD_X_PG_528)) begin
            hit = 1'b1;
            grp = `SFD_GRP_D;
        end
        if (op1_r == `SFD_PFX_RST && b2_r == `SFD_X_ZERO &&
            b3_r == `SFD_X_ZERO && new_byte == `SFD_X_ZERO) begin
            hit    = 1'b1;
            is_rst = 1'b1;
        end
        miss = ~hit;
    end
    is_stat = (byte_cnt_r == 3'h0) &&
              (new_byte == `SFD_OP_STAT || new_byte == `SFD_OP_L_STAT);
    is_bwr  = (byte_cnt_r == 3'h0) &&
              (new_byte == `SFD_OP_B1_WR || new_byte == `SFD_OP_B2_WR);
    rej = 1'b0;
    if (eng_busy && !is_rst) begin
        if (eng_grp_d) begin
            rej = ~is_stat;
        end else begin
            rej = (grp != `SFD_GRP_C) || (is_bwr && bsel == eng_buf);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencing and outputs

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        shift_r      <= 8'h00;
        bit_cnt_r    <= 3'h0;
        byte_cnt_r   <= 3'h0;
        done_r       <= 1'b0;
        rst_arm_r    <= 1'b0;
        op1_r        <= 8'h00;
        b2_r         <= 8'h00;
        b3_r         <= 8'h00;
        cmd_stb_r    <= 1'b0;
        cmd_rej_r    <= 1'b0;
        cmd_unk_r    <= 1'b0;
        cmd_op_r     <= 8'h00;
        cmd_ext_r    <= 8'h00;
        cmd_grp_r    <= `SFD_GRP_OTHER;
        cmd_buf_r    <= 1'b0;
        cmd_legacy_r <= 1'b0;
        st_active_r  <= 1'b0;
        swrst_r      <= 1'b0;
    end else begin
        st_active_r <= eng_busy;
        cmd_stb_r   <= hit & ~rej;
        cmd_rej_r   <= hit & rej;
        cmd_unk_r   <= miss;
        swrst_r     <= cs_rise & rst_arm_r & (bit_cnt_r == 3'h0);
        if (cs_fall || cs_rise) begin
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 3'h0;
            done_r     <= 1'b0;
            rst_arm_r  <= 1'b0;
        end else if (sck_rise) begin
            shift_r   <= new_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (byte_end) begin
                if (byte_cnt_r != `SFD_BYTE_SAT) begin
                    byte_cnt_r <= byte_cnt_r + 3'h1;
                end
                case (byte_cnt_r)
                    3'h0:    op1_r <= new_byte;
                    3'h1:    b2_r  <= new_byte;
                    3'h2:    b3_r  <= new_byte;
                    default: b3_r  <= b3_r;
                endcase
                if (hit || miss) begin
                    done_r <= 1'b1;
                end
                if (is_rst) begin
                    rst_arm_r <= 1'b1;
                end
            end
        end
        if (hit) begin
            cmd_op_r     <= (byte_cnt_r == 3'h0) ? new_byte : op1_r;
            cmd_ext_r    <= (byte_cnt_r == 3'h0) ? `SFD_X_ZERO : new_byte;
            cmd_grp_r    <= grp;
            cmd_buf_r    <= bsel;
            cmd_legacy_r <= legacy;
        end
    end
end

endmodule

//--- tb/sfd_cmd_decoder_monitor.sv
/*
 Port checker for the serial flash command decoder.
 Assumes a bind to sfd_cmd_decoder and one clock, core_clk.
*/
`timescale 1ns/1ps
module sfd_cmd_decoder_monitor (
    input wire       core_clk,
    input wire       rst,
    input wire       cs_n_pin,
    input wire       sck_pin,
    input wire       si_pin,
    input wire       eng_busy,
    input wire       eng_grp_d,
    input wire       eng_buf,
    input wire       cmd_stb_r,
    input wire       cmd_rej_r,
    input wire       cmd_unk_r,
    input wire [7:0] cmd_op_r,
    input wire [7:0] cmd_ext_r,
    input wire [2:0] cmd_grp_r,
    input wire       cmd_buf_r,
    input wire       cmd_legacy_r,
    input wire       st_active_r,
    input wire       swrst_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence pulse_s(x);
        x ##1 !x;
    endsequence
    // Decision seen one edge after the engine inputs
    sequence busy_b_acc_s;
        $past(eng_busy && !eng_grp_d) && cmd_stb_r;
    endsequence
    follow_busy_a: assert property (!$past(rst) |-> st_active_r == $past(eng_busy))
        else $error("busy copy wrong");
    one_verdict_a: assert property ($onehot0({cmd_stb_r, cmd_rej_r, cmd_unk_r}))
        else $error("two verdicts at once");
    stb_pulse_a: assert property (cmd_stb_r |-> pulse_s(cmd_stb_r))
        else $error("accept pulse too long");
    rst_pulse_a: assert property (swrst_r |-> pulse_s(swrst_r))
        else $error("reset pulse too long");
    rst_cmd_a: assert property (swrst_r |-> cmd_op_r == 8'hf0 && cmd_ext_r == 8'h00
        && $past(cs_n_pin, 2)) else $error("reset without its command");
    grpd_only_a: assert property ($past(eng_busy && eng_grp_d) && cmd_stb_r
        |-> cmd_op_r inside {8'hd7, 8'h57, 8'hf0}) else $error("accepted during group D");
    busy_c_a: assert property (busy_b_acc_s |-> cmd_grp_r == 3'h2 || cmd_op_r == 8'hf0)
        else $error("non C accepted while busy");
    buf_other_a: assert property (busy_b_acc_s ##0 (cmd_op_r inside {8'h84, 8'h87})
        |-> cmd_buf_r != $past(eng_buf)) else $error("write to busy buffer");
    rej_cause_a: assert property (cmd_rej_r |-> $past(eng_busy) && cmd_op_r != 8'hf0)
        else $error("refusal while idle");
    c_kept_a: assert property (cmd_rej_r && !$past(eng_grp_d) |-> cmd_grp_r != 3'h2
        || (cmd_op_r[7:4] == 4'h8 && cmd_buf_r == $past(eng_buf))) else $error("C refused");
    fields_hold_a: assert property (!cmd_stb_r && !cmd_rej_r |-> $stable(cmd_op_r)
        && $stable(cmd_grp_r)) else $error("fields moved without verdict");
endmodule

bind sfd_cmd_decoder sfd_cmd_decoder_monitor mon (
    .core_clk(core_clk), .rst(rst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .si_pin(si_pin), .eng_busy(eng_busy), .eng_grp_d(eng_grp_d), .eng_buf(eng_buf),
    .cmd_stb_r(cmd_stb_r), .cmd_rej_r(cmd_rej_r), .cmd_unk_r(cmd_unk_r),
    .cmd_op_r(cmd_op_r), .cmd_ext_r(cmd_ext_r), .cmd_grp_r(cmd_grp_r),
    .cmd_buf_r(cmd_buf_r), .cmd_legacy_r(cmd_legacy_r), .st_active_r(st_active_r),
    .swrst_r(swrst_r)
);

//--- tb/sfd_spi_host.sv
/*
 SPI host model: chip select, serial clock and data, mode 0.
 Assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
module sfd_spi_host (
    output logic cs_n,
    output logic sck,
    output logic si
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task bit_out(input logic b);
        si = b;
        #160 sck = 1'b1;
        #160 sck = 1'b0;
    endtask
    task byte_out(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
    endtask
    // Odd offset keeps the link out of phase with core_clk
    task start();
        #13 cs_n = 1'b0;
        #160;
    endtask
    // each command closed by chip select
    task stop();
        #160 cs_n = 1'b1;
        // No pull on data, so no stale level
        si = ~si;
        #640;
    endtask
endmodule

//--- tb/sfd_cmd_decoder_bench.sv
/*
 Self-checking bench for the command decoder.
 Assumes the SPI host model and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
    $display("Error %0t: got %h exp %h", $time, a, e); end end
module sfd_cmd_decoder_bench;
    typedef struct packed {logic [3:0] k; logic [7:0] op, ext; logic [2:0] g;
        logic b, l;} sfd_note_t;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       eng_busy = 1'b0;
    logic       eng_grp_d = 1'b0;
    logic       eng_buf = 1'b0;
    wire        cs_n, sck, si, stb, rej, unk, bf, lg, st_act, swr;
    wire  [7:0] op, ext;
    wire  [2:0] grp;
    int         bad_count = 0;
    int         checked = 0;
    logic [15:0] lfsr = 16'ha4e0;
    sfd_note_t  q[$];
    logic [15:0] one_t [40] = '{16'hd200, 16'h0100, 16'h0300, 16'h0b00, 16'h1b00, 16'he820,
        16'hd100, 16'hd310, 16'hd400, 16'hd610, 16'h3200, 16'h7700, 16'h5420, 16'h5630,
        16'h5220, 16'h6820, 16'h8301, 16'h8611, 16'h8801, 16'h8911, 16'h8201, 16'h8511,
        16'h0201, 16'h8101, 16'h5001, 16'h7c01, 16'h5801, 16'h5911, 16'h5301, 16'h5511,
        16'h6001, 16'h6111, 16'h8402, 16'h8712, 16'hd702, 16'h9f02, 16'h5722, 16'hb904,
        16'hab04, 16'h7904};
    logic [35:0] four_t [8] = '{36'hc794809a1, 36'h3d2a7fa94, 36'h3d2a7f9a4, 36'h3d2a7fcf3,
        36'h3d2a7ffc3, 36'h3d2a80a63, 36'h3d2a80a73, 36'hf00000004};
    always #20 core_clk = ~core_clk;
    sfd_spi_host host (.cs_n(cs_n), .sck(sck), .si(si));
    sfd_cmd_decoder dut (.core_clk(core_clk), .rst(rst), .cs_n_pin(cs_n), .sck_pin(sck),
        .si_pin(si), .eng_busy(eng_busy), .eng_grp_d(eng_grp_d), .eng_buf(eng_buf),
        .cmd_stb_r(stb), .cmd_rej_r(rej), .cmd_unk_r(unk), .cmd_op_r(op), .cmd_ext_r(ext),
        .cmd_grp_r(grp), .cmd_buf_r(bf), .cmd_legacy_r(lg), .st_active_r(st_act),
        .swrst_r(swr));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [3:0] verdict(input logic [7:0] o, input logic [2:0] g,
        input logic b);
        if (!eng_busy || o == 8'hf0) return 4'h1;
        if (eng_grp_d) return (o == 8'hd7 || o == 8'h57) ? 4'h1 : 4'h2;
        return (g == 3'h2 && !(o[7:4] == 4'h8 && b == eng_buf)) ? 4'h1 : 4'h2;
    endfunction
    task one(input logic [15:0] e, input logic u);
        q.push_back('{u ? 4'h4 : verdict(e[15:8], e[2:0], e[4]), e[15:8], 8'h00, e[2:0],
            e[4], e[5]});
        // Realign, else pin edges drift onto core_clk edges
        @(posedge core_clk);
        host.start();
        host.byte_out(e[15:8]);
        host.byte_out(8'hd7);
        host.stop();
    endtask
    task four(input logic [35:0] e, input logic half);
        q.push_back('{e[3:0] == 4'hf ? 4'h4 : verdict(e[35:28], e[2:0], 1'b0), e[35:28],
            e[11:4], e[2:0], 1'b0, 1'b0});
        if (e[35:28] == 8'hf0 && !half) q.push_back('{4'h8, 8'hf0, 8'h00, 3'h4, 1'b0, 1'b0});
        @(posedge core_clk);
        host.start();
        for (int i = 3; i >= 0; i--) host.byte_out(e[4+8*i +: 8]);
        if (half) for (int i = 0; i < 4; i++) host.bit_out(i[0]);
        host.stop();
    endtask
    task finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        sfd_note_t n;
        logic [3:0] k;
        k = {swr, unk, rej, stb};
        if (k !== 4'h0) begin
            n = (q.size() > 0) ? q.pop_front() : '0;
            `CHK(k, n.k)
            if (n.k < 4'h4) begin
                `CHK(({op, ext, grp}), ({n.op, n.ext, n.g}))
                `CHK(({bf, lg}), ({n.b, n.l}))
            end
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHK(({op, ext, grp, stb, rej, unk, swr, st_act}), ({16'h0000, 3'h4, 5'h00}))
        for (int m = 0; m < 4; m++) begin
            eng_busy <= (m != 0);
            eng_grp_d <= (m == 3);
            eng_buf <= (m == 2);
            repeat (2) @(posedge core_clk);
            `CHK(st_act, (m != 0))
            foreach (one_t[i]) one(one_t[i], 1'b0);
            foreach (four_t[i]) four(four_t[i], 1'b0);
            $display("Engine mode %0d done", m);
        end
        eng_busy <= 1'b0;
        repeat (2) @(posedge core_clk);
        four(36'hf00000004, 1'b1);
        four(36'h3d2a7f00f, 1'b0);
        repeat (24) begin
            logic [15:0] e;
            logic u;
            lfsr = nxt(lfsr);
            e = {lfsr[7:0], 8'h00};
            u = 1'b1;
            foreach (one_t[i]) if (one_t[i][15:8] == e[15:8]) begin e = one_t[i]; u = 1'b0; end
            if (!(e[15:8] inside {8'hc7, 8'h3d, 8'hf0})) one(e, u);
        end
        $display("Unknown and random opcodes done");
        repeat (8) @(posedge core_clk);
        `CHK(q.size(), 0)
        finish_test();
    end
    // About 38k cycles of traffic expected
    initial begin
        #2500000;
        bad_count++;
        $display("Error %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
